// ---- src/patseq_defs.vh ----
`ifndef PATSEQ_DEFS_VH
`define PATSEQ_DEFS_VH

// Opcode encodings carried with each vector
`define OP_W          3
`define OP_NONE       3'h0
`define OP_SCAN       3'h1
`define OP_MATCH      3'h2
`define OP_HALT       3'h3
`define OP_SUSTAIN    3'h4
`define OP_BRANCH     3'h5
`define OP_EXIT_LOOP  3'h6

// Pipeline latency from a match vector to its matched condition
`define MATCH_LATENCY 80

// Scan count width and minimum legal value
`define SCAN_W        16
`define SCAN_MIN      16'h0001

// Sequencer modes
`define MODE_W        4
`define MODE_IDLE     4'h1
`define MODE_RUN      4'h2
`define MODE_SUSTAIN  4'h4
`define MODE_SCAN     4'h8

`endif

// ---- src/match_pipe.v ----
`timescale 1ns/100ps
`default_nettype none
`include "patseq_defs.vh"

// Fixed-latency delay line carrying match results (valid + matched)
module match_pipe #(
	parameter DEPTH = `MATCH_LATENCY
) (
	input  wire clk,
	input  wire reset_n,
	input  wire in_valid,
	input  wire in_matched,
	output wire out_valid,
	output wire out_matched
);

	reg [DEPTH-1:0] valid_sr;
	reg [DEPTH-1:0] match_sr;

	// One stage per cycle, so the result emerges DEPTH cycles later
	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : stage
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					valid_sr[i] <= 1'b0;
					match_sr[i] <= 1'b0;
				end else if (i == 0) begin
					valid_sr[i] <= in_valid;
					match_sr[i] <= in_matched;
				end else begin
					valid_sr[i] <= valid_sr[(i == 0) ? 0 : i-1];
					match_sr[i] <= match_sr[(i == 0) ? 0 : i-1];
				end
			end
		end
	endgenerate

	assign out_valid   = valid_sr[DEPTH-1];
	assign out_matched = match_sr[DEPTH-1];

endmodule

`default_nettype wire

// ---- src/pattern_sequencer.v ----
// Functional notes
// RULE1: Scan opcode expands into count scan subrows
// RULE2: Match compares without touching fail count
// RULE3: Matched condition appears exactly 80 cycles later
// RULE4: Only branch/exit on cycle 80 test it
// RULE5: All comparisons on match vector counted
// RULE6: Pattern uses repeat 79 as filler
// RULE7: Pattern may poll with looped matches
// RULE8: Halt stops sequencer and burst
// RULE9: Pins hold last programmed state after halt
// RULE10: Pattern must end with halt opcode
// RULE11: Sustain opcode jumps to sustain pattern
// RULE12: Leave sustain only on burst or abort
// RULE13: Sustain on sustain's last vector loops
// RULE14: Matched true only if all comparisons pass
`timescale 1ns/100ps
`default_nettype none
`include "patseq_defs.vh"

module pattern_sequencer #(
	parameter PINS    = 8,
	parameter LATENCY = `MATCH_LATENCY
) (
	input  wire            CLK,
	input  wire            RESET_N,
	input  wire            BURST_START,
	input  wire            SUSTAIN_ABORT,
	input  wire            VEC_VALID,
	input  wire [`OP_W-1:0]   VEC_OP,
	input  wire [`SCAN_W-1:0] VEC_SCAN_COUNT,
	input  wire            VEC_LAST,
	input  wire [PINS-1:0] VEC_DRIVE,
	input  wire [PINS-1:0] VEC_DRIVE_EN,
	input  wire [PINS-1:0] CMP_ENABLE,
	input  wire [PINS-1:0] CMP_PASS,
	output reg  [PINS-1:0] PIN_DRIVE,
	output reg  [PINS-1:0] PIN_DRIVE_EN,
	output reg             VEC_ACCEPT,
	output reg             SCAN_ACTIVE,
	output reg             BURST_ACTIVE,
	output reg             SUSTAIN_ACTIVE,
	output reg             SUSTAIN_RESTART,
	output reg             SEQ_HALTED,
	output reg             FAIL_SEEN,
	output reg  [15:0]     FAIL_COUNT,
	output reg             BRANCH_TAKE,
	output reg             BRANCH_VALID,
	output reg             SCAN_ERROR
);

	// One-hot sequencer states
	localparam [`MODE_W-1:0] S_IDLE    = `MODE_IDLE;
	localparam [`MODE_W-1:0] S_RUN     = `MODE_RUN;
	localparam [`MODE_W-1:0] S_SUSTAIN = `MODE_SUSTAIN;
	localparam [`MODE_W-1:0] S_SCAN    = `MODE_SCAN;

	reg  [`MODE_W-1:0] mode;
	reg  [`MODE_W-1:0] next_mode;
	reg  [`SCAN_W-1:0] scan_left;
	wire               pipe_valid;
	wire               pipe_matched;
	wire               step;
	wire               all_pass;
	wire               cmp_fail;
	wire               is_match;
	wire               is_test;
	wire               is_halt;
	wire               is_sustain;
	wire               is_scan;
	wire               scan_long;
	wire               scan_zero;
	wire               scan_done;
	wire               burst_ok;

	// Every enabled comparison must pass
	function pass_all;
		input [PINS-1:0] en;
		input [PINS-1:0] ok;
		begin
			pass_all = &(ok | ~en);
		end
	endfunction

	// States in which offered vectors are executed
	function runs_vectors;
		input [`MODE_W-1:0] m;
		begin
			runs_vectors = (m == S_RUN) || (m == S_SUSTAIN);
		end
	endfunction

	// A vector executes in run or sustain mode when offered
	assign step       = VEC_VALID && runs_vectors(mode);
	assign all_pass   = pass_all(CMP_ENABLE, CMP_PASS); // RULE5 RULE14
	assign is_match   = step && (VEC_OP == `OP_MATCH);
	assign is_halt    = step && (VEC_OP == `OP_HALT);
	assign is_sustain = step && (VEC_OP == `OP_SUSTAIN);
	assign is_scan    = step && (VEC_OP == `OP_SCAN);
	assign is_test    = step && ((VEC_OP == `OP_BRANCH) ||
		(VEC_OP == `OP_EXIT_LOOP));
	// Match vectors never reach the fail tally
	assign cmp_fail   = step && !is_match && !all_pass; // RULE2

	// Scan decode: extra subrows, illegal zero count, last subrow
	assign scan_long  = is_scan && (VEC_SCAN_COUNT > `SCAN_MIN);
	assign scan_zero  = is_scan && (VEC_SCAN_COUNT < `SCAN_MIN);
	assign scan_done  = (scan_left == `SCAN_MIN);
	// A burst is only started from idle or from sustain
	assign burst_ok   = BURST_START &&
		((mode == S_IDLE) || (mode == S_SUSTAIN));

	// Match results delayed by a fixed latency
	match_pipe #(
		.DEPTH(LATENCY)
	) match_pipe_i (
		.clk        (CLK),
		.reset_n    (RESET_N),
		.in_valid   (is_match),        // RULE3
		.in_matched (all_pass),        // RULE14
		.out_valid  (pipe_valid),
		.out_matched(pipe_matched)
	);

	// Mode transitions
	always @* begin
		next_mode = mode;
		case (mode)
			S_IDLE: begin
				if (BURST_START)
					next_mode = S_RUN;
			end
			S_RUN: begin
				if (is_halt)
					next_mode = S_IDLE; // RULE8
				else if (is_sustain)
					next_mode = S_SUSTAIN; // RULE11
				else if (scan_long)
					next_mode = S_SCAN; // RULE1
			end
			S_SCAN: begin
				if (scan_done)
					next_mode = S_RUN; // RULE1
			end
			S_SUSTAIN: begin
				if (BURST_START)
					next_mode = S_RUN; // RULE12
				else if (SUSTAIN_ABORT)
					next_mode = S_IDLE; // RULE12
			end
			default: next_mode = S_IDLE;
		endcase
	end

	// Mode register and scan subrow counter
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mode      <= S_IDLE;
			scan_left <= {`SCAN_W{1'b0}};
		end else begin
			mode <= next_mode;
			// The scan vector's own cycle is its first subrow
			if (mode == S_RUN && scan_long)
				scan_left <= VEC_SCAN_COUNT - `SCAN_MIN; // RULE1
			else if (mode == S_SCAN)
				scan_left <= scan_left - `SCAN_MIN;
		end
	end

	// Pin state, status and compare results
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PIN_DRIVE       <= {PINS{1'b0}};
			PIN_DRIVE_EN    <= {PINS{1'b0}};
			VEC_ACCEPT      <= 1'b0;
			SCAN_ACTIVE     <= 1'b0;
			BURST_ACTIVE    <= 1'b0;
			SUSTAIN_ACTIVE  <= 1'b0;
			SUSTAIN_RESTART <= 1'b0;
			SEQ_HALTED      <= 1'b1;
			FAIL_SEEN       <= 1'b0;
			FAIL_COUNT      <= 16'h0000;
			BRANCH_TAKE     <= 1'b0;
			BRANCH_VALID    <= 1'b0;
			SCAN_ERROR      <= 1'b0;
		end else begin
			// Pins only change on executed vectors; held when halted
			if (step) begin
				PIN_DRIVE    <= VEC_DRIVE;    // RULE9
				PIN_DRIVE_EN <= VEC_DRIVE_EN; // RULE9
			end
			VEC_ACCEPT     <= runs_vectors(next_mode);
			SCAN_ACTIVE    <= (next_mode == S_SCAN);
			BURST_ACTIVE   <= (next_mode == S_RUN) ||
				(next_mode == S_SCAN); // RULE8
			SUSTAIN_ACTIVE <= (next_mode == S_SUSTAIN);
			SEQ_HALTED     <= (next_mode == S_IDLE); // RULE8
			// Sustain opcode on the sustain pattern's last vector loops
			SUSTAIN_RESTART <= (mode == S_SUSTAIN) && is_sustain &&
				VEC_LAST; // RULE13
			if (burst_ok) begin
				FAIL_SEEN  <= 1'b0;
				FAIL_COUNT <= 16'h0000;
				SCAN_ERROR <= 1'b0;
			end else begin
				// Match vectors leave fail results alone
				if (cmp_fail) begin // RULE2
					FAIL_SEEN <= 1'b1;
					if (FAIL_COUNT != 16'hFFFF)
						FAIL_COUNT <= FAIL_COUNT + 16'h0001;
				end
				if (scan_zero)
					SCAN_ERROR <= 1'b1; // RULE1
			end
			// Condition is read only by a test on the 80th cycle
			BRANCH_VALID <= is_test && pipe_valid;     // RULE4
			BRANCH_TAKE  <= is_test && pipe_valid &&
				pipe_matched;                      // RULE3 RULE4
		end
	end

endmodule

`default_nettype wire

// ---- test/seq_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "patseq_defs.vh"
// Mode and match timing watched at the sequencer ports
module seq_checker #(
	parameter PINS    = 8,
	parameter LATENCY = 80
) (
	input wire logic            CLK,
	input wire logic            RESET_N,
	input wire logic            BURST_START,
	input wire logic            SUSTAIN_ABORT,
	input wire logic            VEC_VALID,
	input wire logic [2:0]      VEC_OP,
	input wire logic            VEC_LAST,
	input wire logic [PINS-1:0] CMP_ENABLE,
	input wire logic [PINS-1:0] CMP_PASS,
	input wire logic [PINS-1:0] PIN_DRIVE,
	input wire logic            VEC_ACCEPT,
	input wire logic            BURST_ACTIVE,
	input wire logic            SUSTAIN_ACTIVE,
	input wire logic            SUSTAIN_RESTART,
	input wire logic            SEQ_HALTED,
	input wire logic [15:0]     FAIL_COUNT,
	input wire logic            BRANCH_TAKE,
	input wire logic            BRANCH_VALID
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// Vector executed at this edge, and whether all its compares pass
	wire go = VEC_VALID && VEC_ACCEPT && !BURST_START && !SUSTAIN_ABORT;
	wire ok = &(~CMP_ENABLE | CMP_PASS);
	wire is_m = go && VEC_OP == `OP_MATCH;
	wire is_t = go && (VEC_OP == `OP_BRANCH || VEC_OP == `OP_EXIT_LOOP);
	halt_stops_a: assert property (
		go && BURST_ACTIVE && VEC_OP == `OP_HALT |=> SEQ_HALTED && !VEC_ACCEPT)
		else $error("halt did not stop the burst");
	pins_hold_a: assert property (
		SEQ_HALTED && !BURST_START |=> $stable(PIN_DRIVE))
		else $error("pins moved while halted");
	sustain_enter_a: assert property (
		go && BURST_ACTIVE && VEC_OP == `OP_SUSTAIN |=> SUSTAIN_ACTIVE)
		else $error("sustain opcode did not enter sustain");
	sustain_stay_a: assert property (
		SUSTAIN_ACTIVE && !BURST_START && !SUSTAIN_ABORT |=> SUSTAIN_ACTIVE)
		else $error("sustain left without cause");
	abort_leave_a: assert property (
		SUSTAIN_ACTIVE && SUSTAIN_ABORT && !BURST_START |=> !VEC_ACCEPT)
		else $error("abort did not leave sustain");
	sustain_loop_a: assert property (
		go && SUSTAIN_ACTIVE && VEC_OP == `OP_SUSTAIN && VEC_LAST
		|=> SUSTAIN_RESTART && SUSTAIN_ACTIVE) else $error("no sustain loop");
	match_quiet_a: assert property (
		is_m |=> $stable(FAIL_COUNT)) else $error("match changed fail count");
	match_result_a: assert property (
		is_t && $past(is_m, LATENCY) |=> BRANCH_VALID
		&& BRANCH_TAKE == $past(ok, LATENCY + 1)) else $error("bad match result");
endmodule
bind pattern_sequencer seq_checker #(.PINS(PINS), .LATENCY(LATENCY)) chk_i (.*);
`default_nettype wire

// ---- test/dut_echo.sv ----
`timescale 1ns/100ps
`default_nettype none
// Device pins: driven pins follow the sequencer, released ones wander
module dut_echo (
	input  wire logic       clk,
	input  wire logic [7:0] drv,
	input  wire logic [7:0] en,
	output var  logic [7:0] seen
);
	initial seen = 8'h00;
	// Released pins flip each cycle so no stale level survives
	always @(posedge clk)
		seen <= (drv & en) | (~seen & ~en);
endmodule
`default_nettype wire

// ---- test/pattern_sequencer_match_halt_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "patseq_defs.vh"
module pattern_sequencer_match_halt_tb;
	localparam L = 4;
	reg CLK = 1'h0, RESET_N = 1'h0, BURST_START = 1'h0, SUSTAIN_ABORT = 1'h0;
	reg VEC_VALID = 1'h0, VEC_LAST = 1'h0;
	reg [2:0] VEC_OP = 3'h0;
	reg [15:0] VEC_SCAN_COUNT = 16'h1;
	reg [7:0] VEC_DRIVE = 8'h0, VEC_DRIVE_EN = 8'h0, CMP_ENABLE = 8'h0;
	reg [7:0] CMP_PASS = 8'h0, d, e;
	wire [7:0] PIN_DRIVE, PIN_DRIVE_EN, seen;
	wire VEC_ACCEPT, SCAN_ACTIVE, BURST_ACTIVE, SUSTAIN_ACTIVE, SEQ_HALTED;
	wire SUSTAIN_RESTART, FAIL_SEEN, BRANCH_TAKE, BRANCH_VALID, SCAN_ERROR;
	wire [15:0] FAIL_COUNT;
	integer failures = 0, comparisons = 0, i, k;
	reg [31:0] rs = 32'h1849;
	reg [L-1:0] m;
	pattern_sequencer #(.LATENCY(L)) pattern_sequencer_i (.*);
	dut_echo dut_echo_i (.clk(CLK), .drv(PIN_DRIVE), .en(PIN_DRIVE_EN), .seen(seen));
	always #4 CLK = ~CLK;
	function logic [7:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[7:0];
	endfunction
	function logic all_ok(input logic [7:0] en, pass);
		return &(~en | pass);
	endfunction
	task chk(input string n, input logic [15:0] x, g);
		comparisons = comparisons + 1;
		if (g !== x) begin
			failures = failures + 1;
			$display("BAD %s expected %h seen %h", n, x, g);
		end
	endtask
	// Offer one vector at the falling edge; it runs at the next rising edge
	task vec(input logic [2:0] o, input logic [15:0] c, input logic [7:0] ce, cp);
		VEC_VALID = 1'h1;
		VEC_OP = o;
		VEC_SCAN_COUNT = c;
		VEC_LAST = o == `OP_HALT || o == `OP_SUSTAIN;
		VEC_DRIVE = rnd();
		VEC_DRIVE_EN = rnd();
		CMP_ENABLE = ce;
		CMP_PASS = cp;
		@(negedge CLK);
	endtask
	task close_out;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Cut a hang short well past the expected run length
	initial begin
		#4000;
		failures = failures + 1;
		close_out;
	end
	initial begin
		repeat (2) @(negedge CLK);
		RESET_N = 1'h1;
		BURST_START = 1'h1;
		@(negedge CLK);
		BURST_START = 1'h0;
		// Back-to-back polls, then each result tested exactly L later
		for (k = 0; k < 3; k = k + 1) begin
			for (i = 0; i < L; i = i + 1) begin
				d = (k + i) ? rnd() : 8'h00;
				e = (i == 1) ? 8'hFF : rnd();
				m[i] = all_ok(d, e);
				vec(`OP_MATCH, 16'h1, d, e);
				chk("fail count", 16'h0, FAIL_COUNT);
				chk("fail seen", 16'h0, FAIL_SEEN);
			end
			for (i = 0; i < L; i = i + 1) begin
				vec(i[0] ? `OP_BRANCH : `OP_EXIT_LOOP, 16'h1, 8'h0, 8'h0);
				chk("branch", {1'h1, m[i]}, {BRANCH_VALID, BRANCH_TAKE});
			end
		end
		// A test with no match exactly L earlier sees no condition
		vec(`OP_BRANCH, 16'h1, 8'h0, 8'h0);
		chk("stray branch", 16'h0, {BRANCH_VALID, BRANCH_TAKE});
		// Match, L-1 filler vectors, then the test on the Lth cycle
		d = rnd();
		e = rnd();
		m[0] = all_ok(d, e);
		vec(`OP_MATCH, 16'h1, d, e);
		repeat (L - 1) vec(`OP_NONE, 16'h1, 8'h0, 8'h0);
		vec(`OP_EXIT_LOOP, 16'h1, 8'h0, 8'h0);
		chk("filler branch", {1'h1, m[0]}, {BRANCH_VALID, BRANCH_TAKE});
		vec(`OP_NONE, 16'h1, 8'h01, 8'h00);
		chk("fail count", 16'h1, FAIL_COUNT);
		chk("fail seen", 16'h1, FAIL_SEEN);
		$display("match test done");
		vec(`OP_SCAN, 16'h3, 8'h0, 8'h0);
		VEC_VALID = 1'h0;
		chk("scan", 16'h1, SCAN_ACTIVE);
		@(negedge CLK);
		chk("scan", 16'h2, {SCAN_ACTIVE, VEC_ACCEPT});
		@(negedge CLK);
		chk("scan", 16'h0, SCAN_ACTIVE);
		vec(`OP_SCAN, 16'h0, 8'h0, 8'h0);
		chk("scan error", 16'h1, SCAN_ERROR);
		$display("scan test done");
		vec(`OP_HALT, 16'h1, 8'h0, 8'h0);
		d = VEC_DRIVE;
		e = VEC_DRIVE_EN;
		chk("halted", {1'h1, 1'h0}, {SEQ_HALTED, BURST_ACTIVE});
		repeat (3) vec(`OP_NONE, 16'h1, 8'h0, 8'h0);
		chk("pins", {d, e}, {PIN_DRIVE, PIN_DRIVE_EN});
		chk("device pins", d & e, seen & e);
		$display("halt test done");
		BURST_START = 1'h1;
		@(negedge CLK);
		BURST_START = 1'h0;
		vec(`OP_SUSTAIN, 16'h1, 8'h0, 8'h0);
		chk("sustain", {1'h1, 1'h0}, {SUSTAIN_ACTIVE, BURST_ACTIVE});
		vec(`OP_SUSTAIN, 16'h1, 8'h0, 8'h0);
		chk("restart", 16'h1, SUSTAIN_RESTART);
		VEC_VALID = 1'h0;
		BURST_START = 1'h1;
		@(negedge CLK);
		BURST_START = 1'h0;
		chk("burst", {1'h1, 1'h0}, {BURST_ACTIVE, SUSTAIN_ACTIVE});
		chk("fail count", 16'h0, FAIL_COUNT);
		vec(`OP_SUSTAIN, 16'h1, 8'h0, 8'h0);
		VEC_VALID = 1'h0;
		SUSTAIN_ABORT = 1'h1;
		@(negedge CLK);
		SUSTAIN_ABORT = 1'h0;
		chk("abort", {1'h0, 1'h0}, {SUSTAIN_ACTIVE, VEC_ACCEPT});
		$display("sustain test done");
		close_out;
	end
endmodule
`default_nettype wire
